// ### src/vmei_pkg.sv
package vmei_pkg;

	// ---------------------------------------------------------------
	// field selectors of the control-structure access port
	// ---------------------------------------------------------------
	typedef enum logic [2:0]
	{
		FLD_ENTRY_CTRL = 3'h0,
		FLD_LOAD_COUNT = 3'h1,
		FLD_LOAD_ADDR = 3'h2,
		FLD_INJ_INFO = 3'h3,
		FLD_INJ_ERRCODE = 3'h4,
		FLD_INJ_ILEN = 3'h5,
		FLD_EXIT_REASON = 3'h6,
		FLD_EXIT_QUAL = 3'h7
	} vmei_field_t;

	// ---------------------------------------------------------------
	// entry control vector bits
	// ---------------------------------------------------------------
	localparam int CTL_LONG_GUEST_BIT = 9;
	localparam int CTL_MGMT_ENTRY_BIT = 10;
	localparam int CTL_DUAL_OFF_BIT = 11;

	// ---------------------------------------------------------------
	// injection information layout
	// ---------------------------------------------------------------
	localparam int INFO_VEC_MSB = 7;
	localparam int INFO_TYPE_LSB = 8;
	localparam int INFO_TYPE_MSB = 10;
	localparam int INFO_ERR_BIT = 11;
	localparam int INFO_RSV_LSB = 12;
	localparam int INFO_RSV_MSB = 30;
	localparam int INFO_VALID_BIT = 31;

	typedef enum logic [2:0]
	{
		ITYPE_EXT_INT = 3'h0,
		ITYPE_RSV1 = 3'h1,
		ITYPE_NMI = 3'h2,
		ITYPE_HW_EXC = 3'h3,
		ITYPE_SW_INT = 3'h4,
		ITYPE_PRIV_SW_EXC = 3'h5,
		ITYPE_SW_EXC = 3'h6,
		ITYPE_RSV7 = 3'h7
	} vmei_itype_t;

	// ---------------------------------------------------------------
	// exit reason layout
	// ---------------------------------------------------------------
	localparam int REASON_BASIC_MSB = 15;
	localparam int REASON_ROOT_BIT = 29;
	localparam int REASON_FAIL_BIT = 31;

	// ---------------------------------------------------------------
	// load area: 16-byte entries fetched as two 64-bit words
	// ---------------------------------------------------------------
	localparam logic [63:0] LOAD_WORD_STEP = 64'h8;
	localparam logic [63:0] LOAD_ALIGN_MASK = 64'hf;
	localparam logic [63:0] QUAL_NARROW_MASK = 64'h0000_0000_ffff_ffff;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [31:0] CTRL_RST = 32'h0;
	localparam logic [31:0] WORD_RST = 32'h0;
	localparam logic [63:0] QUAD_RST = 64'h0;

endpackage

// ### src/vmei_inj_decode.sv
`timescale 1ns/1ns
`default_nettype none

module vmei_inj_decode
(
	input wire logic [31:0] info_i,
	output logic valid_o,
	output logic [7:0] vector_o,
	output vmei_pkg::vmei_itype_t type_o,
	output logic push_err_o,
	output logic uses_ilen_o,
	output logic malformed_o
);

	always_comb
	begin
		valid_o = info_i[vmei_pkg::INFO_VALID_BIT];
		vector_o = info_i[vmei_pkg::INFO_VEC_MSB:0];
		type_o = vmei_pkg::vmei_itype_t'(info_i[vmei_pkg::INFO_TYPE_MSB:vmei_pkg::INFO_TYPE_LSB]);
		// error code is only consulted on a valid event with the push bit
		push_err_o = valid_o && info_i[vmei_pkg::INFO_ERR_BIT];
		uses_ilen_o = 1'b0;
		malformed_o = 1'b0;
		case (type_o)
			vmei_pkg::ITYPE_SW_INT,
			vmei_pkg::ITYPE_PRIV_SW_EXC,
			vmei_pkg::ITYPE_SW_EXC:
				uses_ilen_o = 1'b1;
			vmei_pkg::ITYPE_RSV1,
			vmei_pkg::ITYPE_RSV7:
				malformed_o = 1'b1;
			default:
				uses_ilen_o = 1'b0;
		endcase
		if (info_i[vmei_pkg::INFO_RSV_MSB:vmei_pkg::INFO_RSV_LSB] != 19'h0)
			malformed_o = 1'b1;
		malformed_o = malformed_o && valid_o;
	end

endmodule

`default_nettype wire

// ### src/vmei_core.sv
`timescale 1ns/1ns
`default_nettype none

// How it works
// - bit 9 copied into both long-mode flags
// - bit 10 enters management mode, zero outside
// - bit 11 deactivates dual treatment, zero outside
// - wrong reserved control bits fail entry
// - walk count 16-byte entries at address
// - entry: index low, data high quadword
// - injection is last, after all loads
// - bits 7:0 select the vector
// - decode type, reserved values and bits
// - bit 11 pushes an error code
// - inject only when valid bit set
// - error code used only valid plus push
// - software types use the instruction length
// - every exit clears the valid bit
// - exit fields read-only, writes fail
// - reason basic cause, reserved bits zero
// - bit 29 marks exit from root
// - bit 31 marks entry failure
// - qualification recorded, 32 bits without extension
module vmei_core
#(
	parameter bit LONG_MODE_SUPPORTED = 1'b1,
	parameter logic [31:0] CTL_MUST_BE_ONE = 32'h0000_0000,
	parameter logic [31:0] CTL_MAY_BE_ONE = 32'h0000_0e00
)
(
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic fld_wr_i,
	input wire logic fld_rd_i,
	input wire vmei_pkg::vmei_field_t fld_sel_i,
	input wire logic [63:0] fld_wdata_i,
	output logic [63:0] fld_rdata_o,
	output logic fld_rvalid_o,
	output logic fld_wfail_o,
	input wire logic entry_start_i,
	input wire logic in_mgmt_mode_i,
	output logic entry_done_o,
	output logic entry_fail_o,
	output logic long_mode_active_o,
	output logic long_mode_enable_o,
	output logic mgmt_mode_o,
	output logic dual_off_o,
	output logic mem_rd_o,
	output logic [63:0] mem_addr_o,
	input wire logic mem_ack_i,
	input wire logic [63:0] mem_rdata_i,
	output logic reg_load_o,
	output logic [31:0] reg_load_index_o,
	output logic [63:0] reg_load_data_o,
	output logic inject_o,
	output logic [7:0] inject_vector_o,
	output logic [2:0] inject_type_o,
	output logic inject_push_err_o,
	output logic [31:0] inject_err_code_o,
	output logic [31:0] inject_ilen_o,
	input wire logic exit_i,
	input wire logic [15:0] exit_basic_i,
	input wire logic exit_from_root_i,
	input wire logic exit_entry_fail_i,
	input wire logic [63:0] exit_qual_i,
	output logic [31:0] exit_reason_o
);

	typedef enum logic [1:0]
	{
		ST_IDLE = 2'h0,
		ST_LOAD_LO = 2'h1,
		ST_LOAD_HI = 2'h2,
		ST_INJECT = 2'h3
	} vmei_state_t;

	// ---------------------------------------------------------------
	// control-structure fields
	// ---------------------------------------------------------------
	logic [31:0] ctrl_q, ctrl_d, count_q, count_d, info_q, info_d;
	logic [31:0] errc_q, errc_d, ilen_q, ilen_d, reason_q, reason_d;
	logic [63:0] laddr_q, laddr_d, qual_q, qual_d, rdata_q, rdata_d;
	logic rvalid_q, rvalid_d, wfail_q, wfail_d;

	always_comb
	begin
		ctrl_d = ctrl_q;
		count_d = count_q;
		laddr_d = laddr_q;
		info_d = info_q;
		errc_d = errc_q;
		ilen_d = ilen_q;
		reason_d = reason_q;
		qual_d = qual_q;
		wfail_d = 1'b0;
		if (fld_wr_i)
		begin
			case (fld_sel_i)
				vmei_pkg::FLD_ENTRY_CTRL: ctrl_d = fld_wdata_i[31:0];
				vmei_pkg::FLD_LOAD_COUNT: count_d = fld_wdata_i[31:0];
				vmei_pkg::FLD_LOAD_ADDR: laddr_d = fld_wdata_i;
				vmei_pkg::FLD_INJ_INFO: info_d = fld_wdata_i[31:0];
				vmei_pkg::FLD_INJ_ERRCODE: errc_d = fld_wdata_i[31:0];
				vmei_pkg::FLD_INJ_ILEN: ilen_d = fld_wdata_i[31:0];
				default: wfail_d = 1'b1;
			endcase
		end
		if (exit_i)
		begin
			// the exit's valid-bit clear beats a same-cycle software write to the info field; its other bits still land
			info_d[vmei_pkg::INFO_VALID_BIT] = 1'b0;
			reason_d = 32'h0;
			reason_d[vmei_pkg::REASON_BASIC_MSB:0] = exit_basic_i;
			reason_d[vmei_pkg::REASON_ROOT_BIT] = exit_from_root_i;
			reason_d[vmei_pkg::REASON_FAIL_BIT] = exit_entry_fail_i;
			qual_d = LONG_MODE_SUPPORTED ? exit_qual_i
				: (exit_qual_i & vmei_pkg::QUAL_NARROW_MASK);
		end
		rvalid_d = fld_rd_i;
		case (fld_sel_i)
			vmei_pkg::FLD_ENTRY_CTRL: rdata_d = {32'h0, ctrl_q};
			vmei_pkg::FLD_LOAD_COUNT: rdata_d = {32'h0, count_q};
			vmei_pkg::FLD_LOAD_ADDR: rdata_d = laddr_q;
			vmei_pkg::FLD_INJ_INFO: rdata_d = {32'h0, info_q};
			vmei_pkg::FLD_INJ_ERRCODE: rdata_d = {32'h0, errc_q};
			vmei_pkg::FLD_INJ_ILEN: rdata_d = {32'h0, ilen_q};
			vmei_pkg::FLD_EXIT_REASON: rdata_d = {32'h0, reason_q};
			default: rdata_d = qual_q;
		endcase
		if (!fld_rd_i)
			rdata_d = rdata_q;
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			ctrl_q <= vmei_pkg::CTRL_RST;
			count_q <= vmei_pkg::WORD_RST;
			laddr_q <= vmei_pkg::QUAD_RST;
			info_q <= vmei_pkg::WORD_RST;
			errc_q <= vmei_pkg::WORD_RST;
			ilen_q <= vmei_pkg::WORD_RST;
			reason_q <= vmei_pkg::WORD_RST;
			qual_q <= vmei_pkg::QUAD_RST;
			rdata_q <= vmei_pkg::QUAD_RST;
			rvalid_q <= 1'b0;
			wfail_q <= 1'b0;
		end
		else
		begin
			ctrl_q <= ctrl_d;
			count_q <= count_d;
			laddr_q <= laddr_d;
			info_q <= info_d;
			errc_q <= errc_d;
			ilen_q <= ilen_d;
			reason_q <= reason_d;
			qual_q <= qual_d;
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
			wfail_q <= wfail_d;
		end
	end

	assign fld_rdata_o = rdata_q;
	assign fld_rvalid_o = rvalid_q;
	assign fld_wfail_o = wfail_q;
	assign exit_reason_o = reason_q;

	// ---------------------------------------------------------------
	// entry checks and injection decode
	// ---------------------------------------------------------------
	logic inj_valid, inj_push, inj_ilen, inj_bad, ctl_bad;
	logic [7:0] inj_vec;
	vmei_pkg::vmei_itype_t inj_type;

	vmei_inj_decode u_decode
	(
		.info_i(info_q),
		.valid_o(inj_valid),
		.vector_o(inj_vec),
		.type_o(inj_type),
		.push_err_o(inj_push),
		.uses_ilen_o(inj_ilen),
		.malformed_o(inj_bad)
	);

	always_comb
	begin
		ctl_bad = ((ctrl_q & CTL_MUST_BE_ONE) != CTL_MUST_BE_ONE)
			|| ((ctrl_q & ~CTL_MAY_BE_ONE) != 32'h0);
		if (!LONG_MODE_SUPPORTED && ctrl_q[vmei_pkg::CTL_LONG_GUEST_BIT])
			ctl_bad = 1'b1;
		if (!in_mgmt_mode_i && (ctrl_q[vmei_pkg::CTL_MGMT_ENTRY_BIT]
			|| ctrl_q[vmei_pkg::CTL_DUAL_OFF_BIT]))
			ctl_bad = 1'b1;
		// a misaligned load area would fetch torn entries, so refuse it
		if (count_q != 32'h0 && (laddr_q & vmei_pkg::LOAD_ALIGN_MASK) != 64'h0)
			ctl_bad = 1'b1;
		ctl_bad = ctl_bad || inj_bad;
	end

	// ---------------------------------------------------------------
	// entry sequencer
	// ---------------------------------------------------------------
	vmei_state_t state_q, state_d;
	logic [31:0] left_q, left_d, idx_q, idx_d;
	logic [63:0] addr_q, addr_d, ldata_q, ldata_d;
	logic lma_q, lma_d, mgmt_q, mgmt_d, dual_q, dual_d;
	logic done_q, done_d, fail_q, fail_d, load_q, load_d, inj_q, inj_d;
	logic [7:0] ivec_q, ivec_d;
	logic [2:0] itype_q, itype_d;
	logic ipush_q, ipush_d;
	logic [31:0] ierr_q, ierr_d, iilen_q, iilen_d;

	always_comb
	begin
		state_d = state_q;
		left_d = left_q;
		idx_d = idx_q;
		addr_d = addr_q;
		ldata_d = ldata_q;
		lma_d = lma_q;
		mgmt_d = mgmt_q;
		dual_d = dual_q;
		ivec_d = ivec_q;
		itype_d = itype_q;
		ipush_d = ipush_q;
		ierr_d = ierr_q;
		iilen_d = iilen_q;
		done_d = 1'b0;
		fail_d = 1'b0;
		load_d = 1'b0;
		inj_d = 1'b0;
		case (state_q)
			ST_IDLE:
				if (entry_start_i)
				begin
					if (ctl_bad)
						fail_d = 1'b1;
					else
					begin
						lma_d = ctrl_q[vmei_pkg::CTL_LONG_GUEST_BIT];
						mgmt_d = ctrl_q[vmei_pkg::CTL_MGMT_ENTRY_BIT];
						dual_d = ctrl_q[vmei_pkg::CTL_DUAL_OFF_BIT];
						addr_d = laddr_q;
						left_d = count_q;
						state_d = (count_q == 32'h0) ? ST_INJECT : ST_LOAD_LO;
					end
				end
			ST_LOAD_LO:
				if (mem_ack_i)
				begin
					idx_d = mem_rdata_i[31:0];
					addr_d = addr_q + vmei_pkg::LOAD_WORD_STEP;
					state_d = ST_LOAD_HI;
				end
			ST_LOAD_HI:
				if (mem_ack_i)
				begin
					ldata_d = mem_rdata_i;
					load_d = 1'b1;
					addr_d = addr_q + vmei_pkg::LOAD_WORD_STEP;
					left_d = left_q - 32'h1;
					state_d = (left_q == 32'h1) ? ST_INJECT : ST_LOAD_LO;
				end
			ST_INJECT:
			begin
				// reached in the same cycle the last register load goes out on reg_load_o, or straight from idle when the load count is zero
				inj_d = inj_valid;
				ivec_d = inj_vec;
				itype_d = inj_type;
				ipush_d = inj_push;
				ierr_d = inj_push ? errc_q : 32'h0;
				iilen_d = (inj_valid && inj_ilen) ? ilen_q : 32'h0;
				done_d = 1'b1;
				state_d = ST_IDLE;
			end
			default:
				state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			state_q <= ST_IDLE;
			left_q <= vmei_pkg::WORD_RST;
			idx_q <= vmei_pkg::WORD_RST;
			addr_q <= vmei_pkg::QUAD_RST;
			ldata_q <= vmei_pkg::QUAD_RST;
			lma_q <= 1'b0;
			mgmt_q <= 1'b0;
			dual_q <= 1'b0;
			ivec_q <= 8'h0;
			itype_q <= 3'h0;
			ipush_q <= 1'b0;
			ierr_q <= vmei_pkg::WORD_RST;
			iilen_q <= vmei_pkg::WORD_RST;
			done_q <= 1'b0;
			fail_q <= 1'b0;
			load_q <= 1'b0;
			inj_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			left_q <= left_d;
			idx_q <= idx_d;
			addr_q <= addr_d;
			ldata_q <= ldata_d;
			lma_q <= lma_d;
			mgmt_q <= mgmt_d;
			dual_q <= dual_d;
			ivec_q <= ivec_d;
			itype_q <= itype_d;
			ipush_q <= ipush_d;
			ierr_q <= ierr_d;
			iilen_q <= iilen_d;
			done_q <= done_d;
			fail_q <= fail_d;
			load_q <= load_d;
			inj_q <= inj_d;
		end
	end

	assign mem_rd_o = (state_q == ST_LOAD_LO) || (state_q == ST_LOAD_HI);
	assign mem_addr_o = addr_q;
	// both flags carry one flop: paging is always on, so they never differ
	assign long_mode_active_o = lma_q;
	assign long_mode_enable_o = lma_q;
	assign mgmt_mode_o = mgmt_q;
	assign dual_off_o = dual_q;
	assign reg_load_o = load_q;
	assign reg_load_index_o = idx_q;
	assign reg_load_data_o = ldata_q;
	assign inject_o = inj_q;
	assign inject_vector_o = ivec_q;
	assign inject_type_o = itype_q;
	assign inject_push_err_o = ipush_q;
	assign inject_err_code_o = ierr_q;
	assign inject_ilen_o = iilen_q;
	assign entry_done_o = done_q;
	assign entry_fail_o = fail_q;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (srst_i);

	sequence s_accept;
		state_q == ST_IDLE && entry_start_i && !ctl_bad;
	endsequence

	sequence s_hi_ack;
		state_q == ST_LOAD_HI && mem_ack_i;
	endsequence

	chk_long_mode_copy: assert property (s_accept |=> long_mode_active_o == $past(ctrl_q[9])
		&& long_mode_enable_o == long_mode_active_o)
		else $error("long-mode flags not copied from control bit");
	chk_mgmt_outside_fail: assert property (state_q == ST_IDLE && entry_start_i
		&& !in_mgmt_mode_i && (ctrl_q[10] || ctrl_q[11]) |=> entry_fail_o)
		else $error("management controls accepted outside management mode");
	chk_reserved_ctl_fail: assert property (state_q == ST_IDLE && entry_start_i
		&& (ctrl_q & ~CTL_MAY_BE_ONE) != 32'h0 |=> entry_fail_o && !entry_done_o)
		else $error("reserved control bit did not fail the entry");
	chk_load_walk_step: assert property (s_hi_ack |=> reg_load_o
		&& mem_addr_o == $past(mem_addr_o) + 64'h8)
		else $error("load entry not issued or address not stepped");
	chk_inject_last: assert property (inject_o |-> entry_done_o && !mem_rd_o
		&& $past(state_q) == ST_INJECT)
		else $error("injection not the final step of entry");
	chk_inject_valid_only: assert property (inject_o |-> $past(info_q[31]))
		else $error("event injected without valid bit");
	chk_err_code_gate: assert property (inject_err_code_o != 32'h0
		|-> inject_push_err_o)
		else $error("error code presented without push");
	chk_exit_clears_valid: assert property (exit_i |=> !info_q[31])
		else $error("exit left injection valid bit set");
	chk_ro_write_fails: assert property (fld_wr_i && !exit_i
		&& fld_sel_i == vmei_pkg::FLD_EXIT_REASON |=> fld_wfail_o && $stable(reason_q))
		else $error("write to read-only exit field accepted");
	chk_reason_fields: assert property (exit_i |=> reason_q[28:16] == 13'h0 && !reason_q[30]
		&& reason_q[29] == $past(exit_from_root_i)
		&& reason_q[31] == $past(exit_entry_fail_i))
		else $error("exit reason bits wrong");
	chk_info_stable: assert property (!exit_i ##1 1'b1 |-> $stable(qual_q)
		&& $stable(reason_q))
		else $error("exit information changed without an exit");

endmodule

`default_nettype wire

// ### verification/vm_entry_inject_exit_info_tb.sv
`timescale 1ns/1ns
`default_nettype none

module vm_entry_inject_exit_info_tb;

	// ---------------------------------------------------------------
	// stimulus and observed signals
	// ---------------------------------------------------------------
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic fld_wr_i = 1'b0;
	logic fld_rd_i = 1'b0;
	vmei_pkg::vmei_field_t fld_sel_i = vmei_pkg::FLD_ENTRY_CTRL;
	logic [63:0] fld_wdata_i = 64'h0;
	logic entry_start_i = 1'b0;
	logic in_mgmt_mode_i = 1'b0;
	logic mem_ack_i = 1'b0;
	logic [63:0] mem_rdata_i = 64'h0;
	logic exit_i = 1'b0;
	logic [15:0] exit_basic_i = 16'h0;
	logic exit_from_root_i = 1'b0;
	logic exit_entry_fail_i = 1'b0;
	logic [63:0] exit_qual_i = 64'h0;
	logic [63:0] fld_rdata_o;
	logic fld_rvalid_o, fld_wfail_o, entry_done_o, entry_fail_o;
	logic long_mode_active_o, long_mode_enable_o, mgmt_mode_o, dual_off_o, mem_rd_o;
	logic [63:0] mem_addr_o, reg_load_data_o;
	logic [31:0] reg_load_index_o, inject_err_code_o, inject_ilen_o, exit_reason_o;
	logic reg_load_o, inject_o, inject_push_err_o;
	logic [7:0] inject_vector_o;
	logic [2:0] inject_type_o;
	int failures = 0;
	int tests_run = 0;
	int cycles = 0;
	int loads;
	logic [63:0] rd_val;
	logic inj_seen, fail_seen;

	vmei_core dut_u
	(
		.clk_i(clk_i), .srst_i(srst_i), .fld_wr_i(fld_wr_i), .fld_rd_i(fld_rd_i),
		.fld_sel_i(fld_sel_i), .fld_wdata_i(fld_wdata_i), .fld_rdata_o(fld_rdata_o),
		.fld_rvalid_o(fld_rvalid_o), .fld_wfail_o(fld_wfail_o),
		.entry_start_i(entry_start_i), .in_mgmt_mode_i(in_mgmt_mode_i),
		.entry_done_o(entry_done_o), .entry_fail_o(entry_fail_o),
		.long_mode_active_o(long_mode_active_o), .long_mode_enable_o(long_mode_enable_o),
		.mgmt_mode_o(mgmt_mode_o), .dual_off_o(dual_off_o), .mem_rd_o(mem_rd_o),
		.mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i),
		.reg_load_o(reg_load_o), .reg_load_index_o(reg_load_index_o),
		.reg_load_data_o(reg_load_data_o), .inject_o(inject_o),
		.inject_vector_o(inject_vector_o), .inject_type_o(inject_type_o),
		.inject_push_err_o(inject_push_err_o), .inject_err_code_o(inject_err_code_o),
		.inject_ilen_o(inject_ilen_o), .exit_i(exit_i), .exit_basic_i(exit_basic_i),
		.exit_from_root_i(exit_from_root_i), .exit_entry_fail_i(exit_entry_fail_i),
		.exit_qual_i(exit_qual_i), .exit_reason_o(exit_reason_o)
	);

	initial
	begin
		forever #50 clk_i = ~clk_i;
	end

	// ---------------------------------------------------------------
	// memory responder: answers every other cycle, garbage when idle
	// ---------------------------------------------------------------
	always @(posedge clk_i)
	begin
		cycles <= cycles + 1;
		if (mem_rd_o === 1'b1 && mem_ack_i === 1'b0)
		begin
			mem_ack_i <= 1'b1;
			mem_rdata_i <= mem_addr_o[3] ? {32'h5a5a_0000, mem_addr_o[31:0]} :
				{32'hffff_ffff, mem_addr_o[31:0] ^ 32'h0000_c000};
		end
		else
		begin
			mem_ack_i <= 1'b0;
			mem_rdata_i <= ~mem_rdata_i;
		end
		if (cycles == 6000)
		begin
			failures++;
			end_sim();
		end
	end

	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		tests_run++;
		if (got !== exp)
		begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr_fld(input vmei_pkg::vmei_field_t sel, input logic [63:0] d,
		input logic exp_fail);
		logic f;
		@(posedge clk_i);
		fld_wr_i <= 1'b1;
		fld_sel_i <= sel;
		fld_wdata_i <= d;
		@(posedge clk_i);
		fld_wr_i <= 1'b0;
		fld_wdata_i <= ~d;
		#1 f = fld_wfail_o;
		@(posedge clk_i);
		#1 f = f | fld_wfail_o;
		chk("write refused", {63'h0, exp_fail}, {63'h0, f});
	endtask

	task automatic rd_fld(input vmei_pkg::vmei_field_t sel);
		@(posedge clk_i);
		fld_rd_i <= 1'b1;
		fld_sel_i <= sel;
		@(posedge clk_i);
		fld_rd_i <= 1'b0;
		#1 chk("read valid", 64'h1, {63'h0, fld_rvalid_o});
		rd_val = fld_rdata_o;
	endtask

	task automatic setup(input logic [31:0] ctl, input logic [31:0] cnt, input logic [63:0] adr,
		input logic [31:0] info, input logic [31:0] err, input logic [31:0] ilen);
		wr_fld(vmei_pkg::FLD_ENTRY_CTRL, {32'h0, ctl}, 1'b0);
		wr_fld(vmei_pkg::FLD_LOAD_COUNT, {32'h0, cnt}, 1'b0);
		wr_fld(vmei_pkg::FLD_LOAD_ADDR, adr, 1'b0);
		wr_fld(vmei_pkg::FLD_INJ_INFO, {32'h0, info}, 1'b0);
		wr_fld(vmei_pkg::FLD_INJ_ERRCODE, {32'h0, err}, 1'b0);
		wr_fld(vmei_pkg::FLD_INJ_ILEN, {32'h0, ilen}, 1'b0);
	endtask

	// entry k of the table at base: index in the low word, data at +8
	task automatic run_entry(input int n, input logic [63:0] base);
		logic [31:0] lo;
		loads = 0;
		inj_seen = 1'b0;
		fail_seen = 1'b0;
		@(posedge clk_i);
		entry_start_i <= 1'b1;
		@(posedge clk_i);
		entry_start_i <= 1'b0;
		for (int i = 0; i < 60; i++)
		begin
			#1;
			if (reg_load_o === 1'b1)
			begin
				lo = base[31:0] + 32'(loads * 16);
				chk("load index", {32'h0, lo ^ 32'h0000_c000}, {32'h0, reg_load_index_o});
				chk("load data", {32'h5a5a_0000, lo + 32'h8}, reg_load_data_o);
				loads++;
			end
			if (inject_o === 1'b1)
			begin
				inj_seen = 1'b1;
				chk("loads before injection", n, loads);
			end
			fail_seen = fail_seen | (entry_fail_o === 1'b1);
			if (entry_done_o === 1'b1 || entry_fail_o === 1'b1)
				break;
			@(posedge clk_i);
		end
		// a hung entry would otherwise slip through checks that only look for absence
		chk("entry finished", 64'h1, {63'h0, entry_done_o | entry_fail_o});
		chk("walk stopped", 64'h0, {63'h0, mem_rd_o});
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_reset_values();
		for (int i = 0; i < 8; i++)
		begin
			rd_fld(vmei_pkg::vmei_field_t'(i[2:0]));
			chk("field after reset", 64'h0, rd_val);
		end
	endtask

	task automatic t_inject_types();
		logic [2:0] types [6] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
		logic [31:0] info;
		logic [31:0] ctl;
		logic push;
		for (int k = 0; k < 6; k++)
		begin
			push = (types[k] == 3'h3);
			ctl = k[0] ? 32'h0000_0200 : 32'h0;
			info = 32'h8000_0000 | {20'h0, push, types[k], 8'h30 + 8'(k)};
			setup(ctl, 32'h0, 64'h0, info, 32'h0000_1234 + k, 32'h3 + k);
			run_entry(0, 64'h0);
			chk("entry refused", 64'h0, {63'h0, fail_seen});
			chk("injected", 64'h1, {63'h0, inj_seen});
			chk("vector", 64'(8'h30 + 8'(k)), {56'h0, inject_vector_o});
			chk("type", {61'h0, types[k]}, {61'h0, inject_type_o});
			chk("push error", {63'h0, push}, {63'h0, inject_push_err_o});
			chk("error code", push ? 64'h1234 + k : 64'h0, {32'h0, inject_err_code_o});
			chk("length", types[k] >= 3'h4 ? 64'h3 + k : 64'h0, {32'h0, inject_ilen_o});
			chk("long active", {63'h0, ctl[9]}, {63'h0, long_mode_active_o});
			chk("long enable", {63'h0, ctl[9]}, {63'h0, long_mode_enable_o});
		end
		setup(32'h0, 32'h0, 64'h0, 32'h0000_0b0e, 32'h1, 32'h1);
		run_entry(0, 64'h0);
		chk("injected without valid", 64'h0, {63'h0, inj_seen});
	endtask

	task automatic t_refusals();
		logic [31:0] ctl [7] = '{32'h1000, 32'h400, 32'h800, 32'h0, 32'h0, 32'h0, 32'h0};
		logic [31:0] info [7] = '{32'h0, 32'h0, 32'h0, 32'h8000_0100, 32'h8000_0700,
			32'h8000_1000, 32'h0};
		for (int k = 0; k < 7; k++)
		begin
			setup(ctl[k], k == 6 ? 32'h1 : 32'h0, 64'h8, info[k], 32'h0, 32'h0);
			run_entry(0, 64'h8);
			chk("entry refused", 64'h1, {63'h0, fail_seen});
		end
		@(posedge clk_i);
		in_mgmt_mode_i <= 1'b1;
		setup(32'h400, 32'h0, 64'h0, 32'h0, 32'h0, 32'h0);
		run_entry(0, 64'h0);
		chk("management entry", 64'h1, {63'h0, mgmt_mode_o & ~fail_seen});
		setup(32'h800, 32'h0, 64'h0, 32'h0, 32'h0, 32'h0);
		run_entry(0, 64'h0);
		chk("default treatment", 64'h1, {63'h0, dual_off_o & ~mgmt_mode_o});
		@(posedge clk_i);
		in_mgmt_mode_i <= 1'b0;
	endtask

	task automatic t_load_walk();
		setup(32'h0, 32'h2, 64'h1000, 32'h8000_0020, 32'h0, 32'h0);
		run_entry(2, 64'h1000);
		chk("loads", 64'h2, 64'(loads));
		chk("injected last", 64'h1, {63'h0, inj_seen});
	endtask

	task automatic pulse_exit(input logic [15:0] b, input logic root, input logic fl,
		input logic [63:0] q);
		@(posedge clk_i);
		exit_i <= 1'b1;
		exit_basic_i <= b;
		exit_from_root_i <= root;
		exit_entry_fail_i <= fl;
		exit_qual_i <= q;
		@(posedge clk_i);
		exit_i <= 1'b0;
		exit_basic_i <= ~b;
		exit_from_root_i <= ~root;
		exit_entry_fail_i <= ~fl;
		exit_qual_i <= ~q;
		#1;
	endtask

	task automatic t_exit();
		wr_fld(vmei_pkg::FLD_INJ_INFO, 64'h8000_0003, 1'b0);
		pulse_exit(16'h0012, 1'b1, 1'b1, 64'hdead_beef_0123_4567);
		chk("exit reason", 64'ha000_0012, {32'h0, exit_reason_o});
		rd_fld(vmei_pkg::FLD_EXIT_QUAL);
		chk("qualification", 64'hdead_beef_0123_4567, rd_val);
		rd_fld(vmei_pkg::FLD_INJ_INFO);
		chk("valid cleared", 64'h0000_0003, rd_val);
		repeat (5) @(posedge clk_i);
		wr_fld(vmei_pkg::FLD_EXIT_REASON, 64'hffff, 1'b1);
		wr_fld(vmei_pkg::FLD_EXIT_QUAL, 64'h0, 1'b1);
		rd_fld(vmei_pkg::FLD_EXIT_REASON);
		chk("reason held", 64'ha000_0012, rd_val);
		rd_fld(vmei_pkg::FLD_EXIT_QUAL);
		chk("qualification held", 64'hdead_beef_0123_4567, rd_val);
		pulse_exit(16'hffff, 1'b0, 1'b0, 64'h55);
		chk("true exit reason", 64'h0000_ffff, {32'h0, exit_reason_o});
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial
	begin
		repeat (6) @(posedge clk_i);
		srst_i <= 1'b0;
		@(posedge clk_i);
		t_reset_values();
		t_inject_types();
		t_refusals();
		t_load_walk();
		t_exit();
		end_sim();
	end

endmodule

`default_nettype wire
